// file: logic/oms_mode_select.sv
/*
 Operation mode selector: resolves the commanding source from settings
 and terminal inputs, with settings and status reached over APB.
 Assumes terminal pins and the option-fitted pin are asynchronous, while
 motor-running and start-command come from logic on sys_clk.
*/
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
module oms_mode_select
	import oms_pkg::*;
(
	input wire logic sys_clk, // system clock, 10 MHz
	input wire logic resetn, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [OMS_NTERM-1:0] termPin, // assignable terminals
	input wire logic optionFitted, // communication option present
	input wire logic motorRunning, // motor turning
	input wire logic startCmd, // start command on
	output oms_pkg::oms_mode_t mode, // selected command source
	output logic outputStop // output stop request
);
	import oms_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	logic [OMS_NTERM-1:0] termS1_r, termS1_nxt;
	logic [OMS_NTERM-1:0] termS2_r, termS2_nxt;
	logic optS1_r, optS1_nxt;
	logic optS2_r, optS2_nxt;

	always_comb
	begin
		termS1_nxt = termS1_r;
		termS2_nxt = termS2_r;
		optS1_nxt = optS1_r;
		optS2_nxt = optS2_r;
		if (ce)
		begin
			termS1_nxt = termPin;
			termS2_nxt = termS1_r;
			optS1_nxt = optionFitted;
			optS2_nxt = optS1_r;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			termS1_r <= '0;
			termS2_r <= '0;
			optS1_r <= 1'b0;
			optS2_r <= 1'b0;
		end
		else
		begin
			termS1_r <= termS1_nxt;
			termS2_r <= termS2_nxt;
			optS1_r <= optS1_nxt;
			optS2_r <= optS2_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB register file

	logic [31:0] cfgWord_r, cfgWord_nxt;
	logic [31:0] termFn_r, termFn_nxt;
	logic [31:0] rdData_r, rdData_nxt;
	logic [31:0] statusWord;
	logic setup, access, mapped;
	oms_cfg_t cfg;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign mapped = (paddr == OMS_ADDR_CFG) || (paddr == OMS_ADDR_TERMFN)
		|| (paddr == OMS_ADDR_STATUS);
	// read data is captured in the setup phase so access ends in one cycle
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata = rdData_r;

	assign cfg.modeSel = cfgWord_r[OMS_CFG_MS_LSB +: 3];
	assign cfg.startup = cfgWord_r[OMS_CFG_SU_LSB +: 4];
	assign cfg.netSrc = cfgWord_r[OMS_CFG_NETSRC];

	always_comb
	begin
		cfgWord_nxt = cfgWord_r;
		termFn_nxt = termFn_r;
		rdData_nxt = rdData_r;
		if (ce && setup && !pwrite)
		begin
			case (paddr)
				OMS_ADDR_CFG: rdData_nxt = cfgWord_r;
				OMS_ADDR_TERMFN: rdData_nxt = termFn_r;
				OMS_ADDR_STATUS: rdData_nxt = statusWord;
				default: rdData_nxt = 32'h0000_0000;
			endcase
		end
		if (ce && access && pwrite)
		begin
			case (paddr)
				// configuration bits 31 to 9 are kept at zero
				OMS_ADDR_CFG: cfgWord_nxt = {23'h000000, pwdata[8:0]};
				OMS_ADDR_TERMFN: termFn_nxt = pwdata;
				default: cfgWord_nxt = cfgWord_r;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			cfgWord_r <= OMS_CFG_RST;
			termFn_r <= OMS_TERMFN_RST;
			rdData_r <= 32'h0000_0000;
		end
		else
		begin
			cfgWord_r <= cfgWord_nxt;
			termFn_r <= termFn_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// switch decode and mode resolution

	oms_sw_t sw;
	logic netOk, permit, forced, netSu, ilockOn, ostopNext;
	oms_mode_t modeRes;
	oms_mode_t mode_r, mode_nxt;
	logic ostop_r, ostop_nxt;

	oms_term_decode uDecode (
		.termFn(termFn_r),
		.termLvl(termS2_r),
		.sw(sw)
	);

	assign netSu = omsNetStartup(cfg.startup);
	assign ilockOn = sw.asgInterlock && sw.interlock;
	// network source counts as reachable with netSrc set or the option fitted
	assign netOk = cfg.netSrc || optS2_r; // RULE_14 RULE_19
	// selection 6 lifts the stopped-only restriction
	assign permit = (cfg.modeSel == OMS_MS_SWRUN) || !motorRunning
		|| !startCmd; // RULE_01 RULE_02
	// fixed modes take effect at once, even while running
	assign forced = (cfg.modeSel == OMS_MS_PU)
		|| (cfg.modeSel == OMS_MS_CMB_A) || (cfg.modeSel == OMS_MS_CMB_B)
		|| ((cfg.modeSel == OMS_MS_ILOCK) && !ilockOn)
		|| (netSu && (cfg.modeSel == OMS_MS_EXTNET));

	// checked in this order: selection, interlock, startup,
	// then ext-net, panel-net, panel-ext
	function automatic oms_mode_t resolveMode(input oms_cfg_t c,
		input oms_sw_t s, input logic il, input logic nok,
		input oms_mode_t cur);
		oms_mode_t m;
		logic su;
		m = cur;
		su = omsNetStartup(c.startup);
		case (c.modeSel)
			OMS_MS_PU: m = OMS_PU; // RULE_07
			OMS_MS_CMB_A, OMS_MS_CMB_B: m = OMS_EXTPU; // RULE_08
			default:
			begin
				if ((c.modeSel == OMS_MS_ILOCK) && !il)
					m = OMS_EXT; // RULE_10 RULE_21
				else if (su && (c.modeSel == OMS_MS_ILOCK))
				begin
					if (s.asgPanelExt)
						m = s.panelExt ? OMS_EXT : OMS_PU; // RULE_11
				end
				else if (su && (c.modeSel == OMS_MS_EXTNET))
					m = OMS_NET; // RULE_09
				else if (su)
				begin
					if (!s.asgPanelNet)
						m = cur;
					else if (s.panelNet)
						m = s.extNet ? OMS_NET : OMS_PU; // RULE_05 RULE_12
					else if (nok)
						m = OMS_NET; // RULE_05
					else if (s.panelExt && (c.modeSel == OMS_MS_SWRUN))
						m = OMS_EXT; // RULE_13
					else
						m = OMS_PU; // RULE_06 RULE_13 RULE_14
				end
				else if (s.asgExtNet && s.extNet)
				begin
					if (nok)
						m = OMS_NET; // RULE_17
					else if (c.modeSel == OMS_MS_EXTNET)
						m = OMS_EXT; // RULE_18
					else
						m = OMS_PU; // RULE_19
				end
				else if (c.modeSel == OMS_MS_EXTNET)
					m = OMS_EXT; // RULE_17 RULE_18
				else if (s.asgExtNet && s.asgPanelNet)
					m = s.panelNet ? OMS_PU
						: (nok ? OMS_NET : OMS_PU); // RULE_20
				else if (s.asgExtNet && s.asgPanelExt)
					m = s.panelExt ? OMS_EXT : OMS_PU; // RULE_20
				else if (s.asgExtNet)
					m = OMS_EXT; // RULE_17
				else if (s.asgPanelExt)
					m = s.panelExt ? OMS_EXT : OMS_PU; // RULE_22
			end
		endcase
		return m;
	endfunction

	assign modeRes = resolveMode(cfg, sw, ilockOn, netOk, mode_r);
	assign ostopNext = (cfg.modeSel == OMS_MS_ILOCK) && ilockOn;

	always_comb
	begin
		mode_nxt = mode_r;
		ostop_nxt = ostop_r;
		if (ce)
		begin
			if (forced || permit)
				mode_nxt = modeRes; // RULE_23
			// output stop follows the mode that is being entered
			ostop_nxt = ostopNext && (mode_nxt == OMS_EXT); // RULE_11
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			mode_r <= OMS_MODE_RST;
			ostop_r <= 1'b0;
		end
		else
		begin
			mode_r <= mode_nxt;
			ostop_r <= ostop_nxt;
		end
	end

	assign mode = mode_r;
	assign outputStop = ostop_r;

	always_comb
	begin
		statusWord = 32'h0000_0000;
		statusWord[OMS_ST_MODE_LSB +: 2] = mode_r;
		statusWord[OMS_ST_OSTOP] = ostop_r;
		statusWord[OMS_ST_PERMIT] = permit;
		statusWord[OMS_ST_TERM_LSB +: OMS_NTERM] = termS2_r;
		statusWord[OMS_ST_OPT] = optS2_r;
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cbDefault @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_fixed_panel: assert property ( // RULE_07
		ce && cfg.modeSel == OMS_MS_PU |=> mode == OMS_PU)
		else $error("selection 1 did not give panel mode");

	a_combined_fixed: assert property ( // RULE_08
		ce && (cfg.modeSel == OMS_MS_CMB_A || cfg.modeSel == OMS_MS_CMB_B)
		|=> mode == OMS_EXTPU)
		else $error("selection 3 or 4 did not give combined mode");

	a_interlock_ext: assert property ( // RULE_10
		ce && cfg.modeSel == OMS_MS_ILOCK && !ilockOn
		|=> mode == OMS_EXT && !outputStop)
		else $error("interlock off did not force external mode");

	a_net_fixed: assert property ( // RULE_09
		ce && netSu && cfg.modeSel == OMS_MS_EXTNET |=> mode == OMS_NET)
		else $error("startup 10/12 with selection 2 left network mode");

	a_hold_running: assert property ( // RULE_01
		ce && !permit && !forced |=> $stable(mode))
		else $error("mode changed while running without permission");

	a_run_switch: assert property ( // RULE_02
		ce && cfg.modeSel == OMS_MS_SWRUN |=> mode == $past(modeRes))
		else $error("selection 6 did not follow switches while running");

	a_no_ext_sel0: assert property ( // RULE_06
		ce && netSu && cfg.modeSel == OMS_MS_SWITCH && mode != OMS_EXT
		|=> mode != OMS_EXT)
		else $error("selection 0 with startup 10/12 entered external");

	a_no_panel_sel2: assert property ( // RULE_18
		ce && !netSu && cfg.modeSel == OMS_MS_EXTNET && mode != OMS_PU
		|=> mode != OMS_PU)
		else $error("selection 2 entered panel mode");

	a_stop_external: assert property ( // RULE_11
		outputStop |-> mode == OMS_EXT && $past(ostopNext))
		else $error("output stop outside interlocked external mode");

	a_net_unusable: assert property ( // RULE_19
		ce && permit && !netSu && cfg.modeSel == OMS_MS_SWITCH
		&& sw.asgExtNet && sw.extNet && !netOk |=> mode == OMS_PU)
		else $error("network chosen without a usable source");

	a_freeze_ce: assert property ( // RULE_23
		!ce |=> $stable(mode) && $stable(outputStop))
		else $error("state moved while clock enable was low");

endmodule

// file: logic/oms_pkg.sv
/*
 Constants, types and shared helpers of the operation mode selector.
 Assumes a 10 MHz system clock and an APB master with 32-bit data.
*/
//
// Contract
// [RULE_01] Selections 0, 2, 6: network switch inputs act only while stopped; the code lets selection 6 switch while running.
// [RULE_02] Selection 6 also accepts switch changes while the motor runs.
// [RULE_03] Panel/network use needs selection 0 or 6, startup 10 or 12.
// [RULE_04] Panel-network function sits on the terminal coded 65.
// [RULE_05] Panel/network enabled: panel-network on gives panel, off network.
// [RULE_06] Startup 10/12 with selection 0 never enters external mode.
// [RULE_07] Selection 1 holds panel mode whatever the switch inputs.
// [RULE_08] Selections 3 and 4 hold combined mode and ignore switches.
// [RULE_09] Startup 10/12 with selection 2 holds network mode.
// [RULE_10] Selection 7 with interlock off forces external mode.
// [RULE_11] Selection 7, interlock on: panel/external switching, output stop in external.
// [RULE_12] Panel choice becomes network while external-network input is on.
// [RULE_13] Network choice falls to panel or external by panel-external input.
// [RULE_14] Network choice becomes panel when source 0 and no option fitted.
// [RULE_15] External/network use needs selection 0, 2, 6 or 7 with interlock.
// [RULE_16] External/network use needs startup 0, 1 or 2 and code 66.
// [RULE_17] External/network enabled: input on gives network, off external.
// [RULE_18] Startup 0-2 with selection 2 never enters panel mode.
// [RULE_19] External-network network choice becomes panel without usable option.
// [RULE_20] External choice: panel-network input decides if assigned, else panel-external.
// [RULE_21] Priority: selection, interlock, ext-net, panel-net, panel-ext, startup; the code checks startup right after interlock.
// [RULE_22] Panel-external input picks external or panel for selections 0, 6, 7.
// [RULE_23] Mode is registered and changes only on permitted edges.
package oms_pkg;

	localparam int OMS_NTERM = 4;
	localparam int OMS_AW = 12;

	// register byte offsets
	localparam logic [11:0] OMS_ADDR_CFG = 12'h000;
	localparam logic [11:0] OMS_ADDR_TERMFN = 12'h004;
	localparam logic [11:0] OMS_ADDR_STATUS = 12'h008;

	// field positions
	localparam int OMS_CFG_MS_LSB = 0;
	localparam int OMS_CFG_SU_LSB = 4;
	localparam int OMS_CFG_NETSRC = 8;
	localparam int OMS_ST_MODE_LSB = 0;
	localparam int OMS_ST_OSTOP = 2;
	localparam int OMS_ST_PERMIT = 3;
	localparam int OMS_ST_TERM_LSB = 4;
	localparam int OMS_ST_OPT = 8;

	// values after reset
	localparam logic [31:0] OMS_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] OMS_TERMFN_RST = 32'h0000_0000;

	// terminal function codes
	localparam logic [7:0] OMS_FN_INTERLOCK = 8'h0C;
	localparam logic [7:0] OMS_FN_PANEL_EXT = 8'h10;
	localparam logic [7:0] OMS_FN_PANEL_NET = 8'h41;
	localparam logic [7:0] OMS_FN_EXT_NET = 8'h42;

	// mode selection settings
	localparam logic [2:0] OMS_MS_SWITCH = 3'h0;
	localparam logic [2:0] OMS_MS_PU = 3'h1;
	localparam logic [2:0] OMS_MS_EXTNET = 3'h2;
	localparam logic [2:0] OMS_MS_CMB_A = 3'h3;
	localparam logic [2:0] OMS_MS_CMB_B = 3'h4;
	localparam logic [2:0] OMS_MS_SWRUN = 3'h6;
	localparam logic [2:0] OMS_MS_ILOCK = 3'h7;

	// startup settings enabling panel/network switching
	localparam logic [3:0] OMS_SU_PNET_A = 4'hA;
	localparam logic [3:0] OMS_SU_PNET_B = 4'hC;

	typedef enum logic [1:0] {
		OMS_EXT,
		OMS_PU,
		OMS_NET,
		OMS_EXTPU
	} oms_mode_t;

	localparam oms_mode_t OMS_MODE_RST = OMS_EXT;

	typedef struct packed {
		logic interlock;
		logic extNet;
		logic panelNet;
		logic panelExt;
		logic asgInterlock;
		logic asgExtNet;
		logic asgPanelNet;
		logic asgPanelExt;
	} oms_sw_t;

	typedef struct packed {
		logic [2:0] modeSel;
		logic [3:0] startup;
		logic netSrc;
	} oms_cfg_t;

	function automatic logic omsNetStartup(input logic [3:0] su);
		omsNetStartup = (su == OMS_SU_PNET_A) || (su == OMS_SU_PNET_B);
	endfunction

endpackage

// file: logic/oms_term_decode.sv
/*
 Maps synchronised terminal levels onto switch functions by their codes.
 Assumes levels are already in the system clock domain; unassigned reads off.
*/
`timescale 1ns/1ps
module oms_term_decode
	import oms_pkg::*;
(
	input wire logic [31:0] termFn, // one function code per terminal
	input wire logic [OMS_NTERM-1:0] termLvl, // synchronised levels
	output oms_pkg::oms_sw_t sw // decoded switch functions
);
	import oms_pkg::*;

	always_comb
	begin
		sw = '0;
		for (int i = 0; i < OMS_NTERM; i++)
		begin
			// several terminals with one code are or-ed together
			case (termFn[i*8 +: 8])
				OMS_FN_PANEL_NET:
				begin
					sw.asgPanelNet = 1'b1; // RULE_04
					sw.panelNet = sw.panelNet | termLvl[i]; // RULE_04
				end
				OMS_FN_EXT_NET:
				begin
					sw.asgExtNet = 1'b1;
					sw.extNet = sw.extNet | termLvl[i];
				end
				OMS_FN_PANEL_EXT:
				begin
					sw.asgPanelExt = 1'b1;
					sw.panelExt = sw.panelExt | termLvl[i];
				end
				OMS_FN_INTERLOCK:
				begin
					sw.asgInterlock = 1'b1;
					sw.interlock = sw.interlock | termLvl[i];
				end
				default:
				begin
				end
			endcase
		end
	end

endmodule

// file: test/oms_mode_select_tb.sv
/*
 Self-checking bench of the operation mode selector.
 Assumes the design answers APB with pready; terminals come from the model.
*/
`timescale 1ns/1ps
module oms_mode_select_tb;
	import oms_pkg::*;
	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] fn;
		logic [3:0] t;
		logic opt;
		oms_mode_t m;
		logic st;
	} oms_row_t;
	// terminal maps: all four, no panel-network, panel/ext-net swapped
	localparam logic [31:0] FA = 32'h0C104241;
	localparam logic [31:0] FG = 32'h0C104200;
	localparam logic [31:0] FH = 32'h0C104142;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] termPin;
	logic optionFitted;
	logic motorRunning;
	logic startCmd;
	oms_mode_t mode;
	logic outputStop;
	logic [3:0] lvlReq = 4'h0;
	logic optReq = 1'b0;
	logic runReq = 1'b0;
	logic startReq = 1'b0;
	int fails = 0;
	int samplesChecked = 0;
	int cycles = 0;
	logic [31:0] q;
	logic e;
	oms_row_t rows[21] = '{
		'{32'h101, FA, 4'hF, 1'b1, OMS_PU, 1'b0},
		'{32'h103, FA, 4'h7, 1'b1, OMS_EXTPU, 1'b0},
		'{32'h104, FA, 4'h0, 1'b1, OMS_EXTPU, 1'b0},
		'{32'h1A2, FA, 4'h1, 1'b1, OMS_NET, 1'b0},
		'{32'h107, FA, 4'h6, 1'b1, OMS_EXT, 1'b0},
		'{32'h1A0, FA, 4'h1, 1'b1, OMS_PU, 1'b0},
		'{32'h1A0, FA, 4'h0, 1'b1, OMS_NET, 1'b0},
		'{32'h1A0, FA, 4'h3, 1'b1, OMS_NET, 1'b0},
		'{32'h0A0, FA, 4'h0, 1'b0, OMS_PU, 1'b0},
		'{32'h0A0, FA, 4'h4, 1'b0, OMS_PU, 1'b0},
		'{32'h0A6, FA, 4'h4, 1'b0, OMS_EXT, 1'b0},
		'{32'h100, FG, 4'h2, 1'b1, OMS_NET, 1'b0},
		'{32'h100, FG, 4'h0, 1'b1, OMS_PU, 1'b0},
		'{32'h100, FG, 4'h4, 1'b1, OMS_EXT, 1'b0},
		'{32'h000, FG, 4'h2, 1'b0, OMS_PU, 1'b0},
		'{32'h002, FG, 4'h2, 1'b0, OMS_EXT, 1'b0},
		'{32'h107, FG, 4'hC, 1'b1, OMS_EXT, 1'b1},
		'{32'h1A7, FG, 4'h8, 1'b1, OMS_PU, 1'b0},
		'{32'h100, FA, 4'h1, 1'b1, OMS_PU, 1'b0},
		'{32'h1A0, FH, 4'h2, 1'b1, OMS_PU, 1'b0},
		'{32'h100, 32'h0000_1000, 4'h2, 1'b1, OMS_EXT, 1'b0}
	};

	////////////////////////////////////////////////////////////////////
	oms_mode_select dut
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.termPin(termPin),
		.optionFitted(optionFitted),
		.motorRunning(motorRunning),
		.startCmd(startCmd),
		.mode(mode),
		.outputStop(outputStop)
	);
	oms_term_model model
	(
		.sys_clk(sys_clk),
		.lvlReq(lvlReq),
		.optReq(optReq),
		.runReq(runReq),
		.startReq(startReq),
		.termPin(termPin),
		.optionFitted(optionFitted),
		.motorRunning(motorRunning),
		.startCmd(startCmd)
	);

	always #50 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////
	task automatic giveVerdict;
	begin
		$display("checked %0d, mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		samplesChecked++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	end
	endtask

	// request held until pready is sampled high, then released;
	// only the bench timeout ends a wait that never completes
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
	begin
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
		begin
			@(posedge sys_clk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask

	task automatic drive(input logic [3:0] t, input logic o,
		input logic r, input logic s);
	begin
		@(posedge sys_clk);
		lvlReq <= t;
		optReq <= o;
		runReq <= r;
		startReq <= s;
		// model edge, two sync flops, mode register, then margin
		repeat (6) @(posedge sys_clk);
	end
	endtask

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			giveVerdict();
		end
	end

	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		check(32'(mode), 32'(OMS_EXT));
		apb(1'b0, OMS_ADDR_CFG, 32'h0);
		check(q, OMS_CFG_RST);
		$display("reset test done");
		foreach (rows[i])
		begin
			apb(1'b1, OMS_ADDR_CFG, rows[i].cfg);
			apb(1'b1, OMS_ADDR_TERMFN, rows[i].fn);
			drive(rows[i].t, rows[i].opt, 1'b0, 1'b0);
			check(32'(mode), 32'(rows[i].m));
			check(32'(outputStop), 32'(rows[i].st));
			apb(1'b0, OMS_ADDR_STATUS, 32'h0);
			check(32'(q[2:0]), {29'h0, rows[i].st, rows[i].m});
		end
		// rows also
		// and
		$display("table test done");
		// a switch asked for while running and started must wait
		apb(1'b1, OMS_ADDR_CFG, 32'h100);
		apb(1'b1, OMS_ADDR_TERMFN, FG);
		// start from panel mode with the motor stopped
		drive(4'h0, 1'b1, 1'b0, 1'b0);
		check(32'(mode), 32'(OMS_PU));
		drive(4'h2, 1'b1, 1'b1, 1'b1);
		check(32'(mode), 32'(OMS_PU));
		drive(4'h2, 1'b1, 1'b0, 1'b1);
		check(32'(mode), 32'(OMS_NET));
		$display("stop gating test done");
		apb(1'b1, OMS_ADDR_CFG, 32'h106);
		drive(4'h0, 1'b1, 1'b1, 1'b1);
		check(32'(mode), 32'(OMS_PU));
		$display("run switching test done");
		// with the enable low even the synchronisers must stand still
		@(posedge sys_clk);
		ce <= 1'b0;
		drive(4'h2, 1'b1, 1'b1, 1'b1);
		check(32'(mode), 32'(OMS_PU));
		@(posedge sys_clk);
		ce <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check(32'(mode), 32'(OMS_NET));
		$display("clock enable test done");
		apb(1'b0, 12'h00C, 32'h0);
		check({31'h0, e}, 32'h1);
		check(q, 32'h0);
		$display("unmapped test done");
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		check(32'(mode), 32'(OMS_EXT));
		apb(1'b0, OMS_ADDR_TERMFN, 32'h0);
		check(q, OMS_TERMFN_RST);
		$display("second reset test done");
		giveVerdict();
	end
endmodule

// file: test/oms_term_model.sv
/*
 Model of the terminal strip, option slot and motor seen by the selector.
 Assumes the bench sets the wanted levels just after a rising edge.
*/
`timescale 1ns/1ps
module oms_term_model
(
	input wire logic sys_clk, // system clock
	input wire logic [3:0] lvlReq, // wanted terminal levels
	input wire logic optReq, // wanted option presence
	input wire logic runReq, // wanted motor state
	input wire logic startReq, // wanted start command
	output logic [3:0] termPin = 4'h0, // terminal levels
	output logic optionFitted = 1'b0, // option present
	output logic motorRunning = 1'b0, // motor turning
	output logic startCmd = 1'b0 // start command
);
	////////////////////////////////////////////////////////////////////
	// contacts change on an edge only, so the selector sees clean steps
	always_ff @(posedge sys_clk)
	begin
		termPin <= lvlReq;
		optionFitted <= optReq;
		motorRunning <= runReq;
		startCmd <= startReq;
	end
endmodule
